//--- verilog/twowire_iface.sv
// two-wire interface: software master and hardware slave
// What this block does
// - master select one gives software master; zero gives hardware slave
// - master mode: data pin driven to data output bit while enabled
// - master mode: clock pin always driven, following clock output bit
// - drive enable cleared releases the data pin for input
// - drive disabled: data pin sampled on each rising serial clock edge
// - after reset the block is a hardware slave
// - interface works only while serial peripheral select is cleared
// - slave sets byte-done after start, matching address and direction
// - interrupt only with enable bit 01H and global enable both set
// - a read or write of byte data clears byte-done, except in the cycle a byte ends
// - second data access per interrupt halts slave until interface reset
// - interrupt vectors to 003BH after each complete byte
// - first byte places 7-bit address and direction in byte data
// - direction flag holds master's read bit; one transmits, zero receives
// - after valid address, clock held low until byte-done is cleared
// - byte flagged only when acknowledged; nack raises no flag
// - every completed byte flagged until stop or interface reset
// - stop, or nack ending a sequence, returns slave to idle
// - interface reset bit forces slave back to idle
// - address and data interrupts look identical in hardware
// - spikes under 50 ns rejected on both lines
// - slave held in reset while interface reset bit is one; master mode ignores it
`timescale 1ns/10ps
module twowire_iface
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        linkClk,
  input  wire logic        sclPin,
  input  wire logic        sdaPin,
  output logic             sclOut,
  output logic             sclOe_n,
  output logic             sdaOut,
  output logic             sdaOe_n,
  input  wire logic        masterSelectBit,
  input  wire logic        sdaDriveEnable,
  input  wire logic        sdaOutValue,
  input  wire logic        sclOutValue,
  output logic             sdaSampledIn,
  input  wire logic        serialPeriphSelectBit,
  input  wire logic        interfaceResetBit,
  input  wire logic [7:0]  interruptEnableReg2,
  input  wire logic        globalIrqEnable,
  input  wire logic        ownAddrWrite,
  input  wire logic [7:0]  ownAddrData,
  output logic [7:0]       ownAddress,
  input  wire logic        dataWrite,
  input  wire logic        dataRead,
  input  wire logic [7:0]  dataWrData,
  output logic [7:0]       byteData,
  output logic             byteDoneFlag,
  output logic             transmitDirectionFlag,
  output logic             slaveHalted,
  output logic             coreIrq,
  output logic [15:0]      irqVector
);
  function automatic logic [3:0] bump(input logic [3:0] c);
    return c + 4'h1;
  endfunction : bump

  twowire_lines_if lines ();
  logic                      sclNow, sdaNow, sclPrev_reg, sdaPrev_reg;
  logic                      sclRise, sclFall, startSeen, stopSeen;
  logic                      masterMode, slaveActive, dataAccess, haltNow;
  logic                      byteEnd, hwLoad, addrMatch, sclHold;
  logic                      sdaPullLow, ackOk_reg, accessed_reg;
  twowire_pkg::slave_state_e state_reg;
  logic [3:0]                bitCnt_reg;
  logic [7:0]                shift_reg, byteData_reg, ownAddress_reg;
  logic                      byteDoneFlag_reg, transmitDirectionFlag_reg;
  logic                      sdaSampledIn_reg, coreIrq_reg, sclOut_reg;
  logic                      sclOe_n_reg, sdaOut_reg, sdaOe_n_reg;

  // link clock must run freely: the filter has to see every line change
  line_filter u_filter
  (
    .linkClk (linkClk),
    .sys_rst (sys_rst),
    .sclPin  (sclPin),
    .sdaPin  (sdaPin),
    .lines   (lines.filt)
  );

  line_sync u_sync
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .lines   (lines.core),
    .sclNow  (sclNow),
    .sdaNow  (sdaNow)
  );

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      sclPrev_reg <= twowire_pkg::LINES_IDLE[1];
      sdaPrev_reg <= twowire_pkg::LINES_IDLE[0];
    end
    else
    begin
      sclPrev_reg <= sclNow;
      sdaPrev_reg <= sdaNow;
    end

  assign sclRise   = sclNow & ~sclPrev_reg;
  assign sclFall   = ~sclNow & sclPrev_reg;
  assign startSeen = sclNow & sclPrev_reg & sdaPrev_reg & ~sdaNow;
  assign stopSeen  = sclNow & sclPrev_reg & ~sdaPrev_reg & sdaNow;

  assign masterMode  = masterSelectBit & ~serialPeriphSelectBit;
  assign slaveActive = ~masterSelectBit & ~serialPeriphSelectBit
                     & ~interfaceResetBit;
  assign dataAccess  = dataWrite | dataRead;
  assign haltNow     = slaveActive & dataAccess & accessed_reg;
  assign addrMatch   = shift_reg[7:1] == ownAddress_reg[6:0];

  // one flag for address and data bytes alike
  always_comb
  begin
    byteEnd = 1'b0;
    hwLoad  = 1'b0;
    if (slaveActive && !haltNow && !stopSeen && !startSeen && sclFall
        && bitCnt_reg == twowire_pkg::ACK_CLOCKED)
      case (state_reg)
        twowire_pkg::ST_AACK, twowire_pkg::ST_RACK:
        begin
          byteEnd = 1'b1;
          hwLoad  = 1'b1;
        end
        twowire_pkg::ST_TACK: byteEnd = ackOk_reg;
        default: byteEnd = 1'b0;
      endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      state_reg  <= twowire_pkg::ST_IDLE;
      bitCnt_reg <= twowire_pkg::COUNT_RESET;
      shift_reg  <= twowire_pkg::BYTE_DATA_RESET;
      ackOk_reg  <= 1'b0;
    end
    else if (!slaveActive)
    begin
      state_reg  <= twowire_pkg::ST_IDLE;
      bitCnt_reg <= twowire_pkg::COUNT_RESET;
    end
    else if (state_reg == twowire_pkg::ST_HALT)
      state_reg <= twowire_pkg::ST_HALT;
    else if (haltNow)
      state_reg <= twowire_pkg::ST_HALT;
    else if (stopSeen)
      state_reg <= twowire_pkg::ST_IDLE;
    else if (startSeen)
    begin
      state_reg  <= twowire_pkg::ST_ADDR;
      bitCnt_reg <= twowire_pkg::COUNT_RESET;
    end
    else
      case (state_reg)
        twowire_pkg::ST_ADDR, twowire_pkg::ST_RXD:
          if (sclRise)
          begin
            shift_reg  <= {shift_reg[6:0], sdaNow};
            bitCnt_reg <= bump(bitCnt_reg);
          end
          else if (sclFall && bitCnt_reg == twowire_pkg::BITS_PER_BYTE)
          begin
            bitCnt_reg <= twowire_pkg::COUNT_RESET;
            if (state_reg == twowire_pkg::ST_RXD)
              state_reg <= twowire_pkg::ST_RACK;
            else if (addrMatch)
              state_reg <= twowire_pkg::ST_AACK;
            else
              state_reg <= twowire_pkg::ST_IDLE;
          end
        twowire_pkg::ST_AACK, twowire_pkg::ST_RACK:
          if (sclRise)
            bitCnt_reg <= bump(bitCnt_reg);
          else if (byteEnd)
            state_reg <= twowire_pkg::ST_HOLD;
        twowire_pkg::ST_HOLD:
          if (!byteDoneFlag_reg)
          begin
            bitCnt_reg <= twowire_pkg::COUNT_RESET;
            if (transmitDirectionFlag_reg)
            begin
              state_reg <= twowire_pkg::ST_TXD;
              shift_reg <= byteData_reg;
            end
            else
              state_reg <= twowire_pkg::ST_RXD;
          end
        twowire_pkg::ST_TXD:
          if (sclRise)
            bitCnt_reg <= bump(bitCnt_reg);
          else if (sclFall && bitCnt_reg == twowire_pkg::BITS_PER_BYTE)
          begin
            state_reg  <= twowire_pkg::ST_TACK;
            bitCnt_reg <= twowire_pkg::COUNT_RESET;
          end
          else if (sclFall)
            shift_reg <= {shift_reg[6:0], 1'b0};
        twowire_pkg::ST_TACK:
          if (sclRise)
          begin
            ackOk_reg  <= ~sdaNow;
            bitCnt_reg <= bump(bitCnt_reg);
          end
          else if (sclFall && bitCnt_reg == twowire_pkg::ACK_CLOCKED)
            state_reg <= ackOk_reg ? twowire_pkg::ST_HOLD
                                   : twowire_pkg::ST_IDLE;
        default: state_reg <= twowire_pkg::ST_IDLE;
      endcase

  // an access in the same cycle as a new byte is charged to the old one
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      accessed_reg <= 1'b0;
    else if (!slaveActive || byteEnd)
      accessed_reg <= 1'b0;
    else if (dataAccess)
      accessed_reg <= 1'b1;

  // hardware set wins over the clearing access
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      byteDoneFlag_reg <= 1'b0;
    else if (!slaveActive)
      byteDoneFlag_reg <= 1'b0;
    else if (byteEnd)
      byteDoneFlag_reg <= 1'b1;
    else if (dataAccess)
      byteDoneFlag_reg <= 1'b0;

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      transmitDirectionFlag_reg <= 1'b0;
    else if (!slaveActive)
      transmitDirectionFlag_reg <= 1'b0;
    else if (hwLoad && state_reg == twowire_pkg::ST_AACK)
      transmitDirectionFlag_reg <= shift_reg[0];
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      byteData_reg <= twowire_pkg::BYTE_DATA_RESET;
    else if (hwLoad)
      byteData_reg <= shift_reg;
    else if (dataWrite)
      byteData_reg <= dataWrData;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      ownAddress_reg <= twowire_pkg::OWN_ADDR_RESET;
    else if (ownAddrWrite)
      ownAddress_reg <= ownAddrData;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      sdaSampledIn_reg <= 1'b0;
    else if (masterMode && !sdaDriveEnable && sclRise)
      sdaSampledIn_reg <= sdaNow;
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      coreIrq_reg <= 1'b0;
    else
      coreIrq_reg <= byteDoneFlag_reg & globalIrqEnable
                   & interruptEnableReg2[twowire_pkg::IE2_TWI_BIT];

  assign sclHold    = slaveActive && state_reg == twowire_pkg::ST_HOLD
                    && byteDoneFlag_reg;
  assign sdaPullLow = slaveActive
                    && (state_reg == twowire_pkg::ST_AACK
                    || state_reg == twowire_pkg::ST_RACK
                    || (state_reg == twowire_pkg::ST_TXD
                    && !shift_reg[7]));

  // pins are registered so no decode glitch ever reaches the bus
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      sclOut_reg  <= twowire_pkg::PIN_LOW;
      sclOe_n_reg <= twowire_pkg::OE_N_RELEASED;
      sdaOut_reg  <= twowire_pkg::PIN_LOW;
      sdaOe_n_reg <= twowire_pkg::OE_N_RELEASED;
    end
    else if (masterMode)
    begin
      sclOut_reg  <= sclOutValue;
      sclOe_n_reg <= 1'b0;
      sdaOut_reg  <= sdaOutValue;
      sdaOe_n_reg <= ~sdaDriveEnable;
    end
    else
    begin
      sclOut_reg  <= twowire_pkg::PIN_LOW;
      sclOe_n_reg <= ~sclHold;
      sdaOut_reg  <= twowire_pkg::PIN_LOW;
      sdaOe_n_reg <= ~sdaPullLow;
    end

  assign sclOut                = sclOut_reg;
  assign sclOe_n               = sclOe_n_reg;
  assign sdaOut                = sdaOut_reg;
  assign sdaOe_n               = sdaOe_n_reg;
  assign sdaSampledIn          = sdaSampledIn_reg;
  assign ownAddress            = ownAddress_reg;
  assign byteData              = byteData_reg;
  assign byteDoneFlag          = byteDoneFlag_reg;
  assign transmitDirectionFlag = transmitDirectionFlag_reg;
  assign slaveHalted           = state_reg == twowire_pkg::ST_HALT;
  assign coreIrq               = coreIrq_reg;
  assign irqVector             = twowire_pkg::IRQ_VECTOR;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_master_scl: assert property (
    masterMode |=> !sclOe_n && sclOut == $past(sclOutValue))
    else $error("clock pin does not follow clock output bit");
  a_master_sda: assert property (
    masterMode && sdaDriveEnable |=> !sdaOe_n && sdaOut == $past(sdaOutValue))
    else $error("data pin does not follow data output bit");
  a_sda_released: assert property (
    masterMode && !sdaDriveEnable |=> sdaOe_n)
    else $error("data pin driven while drive enable is clear");
  a_sample_rise: assert property (
    masterMode && !sdaDriveEnable && sclRise |=> sdaSampledIn == $past(sdaNow))
    else $error("data pin not captured on clock rise");
  a_access_clears: assert property (
    dataAccess && !byteEnd && slaveActive |=> !byteDoneFlag)
    else $error("byte-done survived a data access");
  a_double_halts: assert property (
    haltNow |=> slaveHalted)
    else $error("second access did not halt the slave");
  a_halt_sticks: assert property (
    slaveHalted && slaveActive |=> slaveHalted)
    else $error("halted slave left halt without interface reset");
  a_addr_flag: assert property (
    byteEnd && state_reg == twowire_pkg::ST_AACK
    |=> byteDoneFlag && byteData == $past(shift_reg)
        && transmitDirectionFlag == $past(shift_reg[0]))
    else $error("address byte not flagged with direction");
  a_stretch_scl: assert property (
    sclHold |=> !sclOe_n && !sclOut)
    else $error("clock not held low while byte-done is set");
  a_irq_gate: assert property (
    coreIrq |-> $past(byteDoneFlag && globalIrqEnable
                      && interruptEnableReg2[0]))
    else $error("interrupt raised without both enables");
  a_nack_idle: assert property (
    slaveActive && state_reg == twowire_pkg::ST_TACK && sclFall
    && bitCnt_reg == twowire_pkg::ACK_CLOCKED && !ackOk_reg
    && !haltNow && !startSeen
    |=> state_reg == twowire_pkg::ST_IDLE && !byteDoneFlag)
    else $error("nack did not return to idle unflagged");
  a_iface_reset: assert property (
    interfaceResetBit |=> state_reg == twowire_pkg::ST_IDLE && !byteDoneFlag)
    else $error("interface reset did not force idle");
  a_addr_mismatch: assert property (
    slaveActive && state_reg == twowire_pkg::ST_ADDR && sclFall
    && bitCnt_reg == twowire_pkg::BITS_PER_BYTE && !addrMatch
    && !haltNow && !stopSeen && !startSeen
    |=> state_reg == twowire_pkg::ST_IDLE)
    else $error("foreign address not ignored");
endmodule : twowire_iface

//--- verilog/twowire_pkg.sv
// shared constants and state type for the two-wire interface
package twowire_pkg;
  localparam int          LINK_PERIOD_NS  = 30;
  localparam int          GLITCH_NS       = 50;
  // three agreeing samples span 60 ns, so no spike under 50 ns gets through
  localparam int          FILTER_CYCLES   =
    (GLITCH_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS + 1;
  localparam logic [1:0]  LINES_IDLE      = 2'h3;
  localparam logic        OE_N_RELEASED   = 1'b1;
  localparam logic        PIN_LOW         = 1'b0;
  localparam logic [15:0] IRQ_VECTOR      = 16'h003B;
  localparam int          IE2_TWI_BIT     = 0;
  localparam logic [7:0]  BYTE_DATA_RESET = 8'h00;
  localparam logic [7:0]  OWN_ADDR_RESET  = 8'h55;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
  localparam logic [3:0]  ACK_CLOCKED     = 4'h1;
  localparam logic [3:0]  COUNT_RESET     = 4'h0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_AACK = 4'h3,
    ST_HOLD = 4'h2,
    ST_RXD  = 4'h6,
    ST_RACK = 4'h7,
    ST_TXD  = 4'h5,
    ST_TACK = 4'h4,
    ST_HALT = 4'hC
  } slave_state_e;
endpackage : twowire_pkg

//--- verilog/twowire_lines_if.sv
// filtered bus line levels handed from the link clock to the core
`timescale 1ns/10ps
interface twowire_lines_if;
  logic scl;
  logic sda;
  modport filt (output scl, output sda);
  modport core (input scl, input sda);
endinterface : twowire_lines_if

//--- verilog/line_filter.sv
// spike filter for both bus lines, clocked by the link clock
`timescale 1ns/10ps
module line_filter #(
  parameter int CYCLES = twowire_pkg::FILTER_CYCLES
)
(
  input  wire logic     linkClk,
  input  wire logic     sys_rst,
  input  wire logic     sclPin,
  input  wire logic     sdaPin,
  twowire_lines_if.filt lines
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [1:0] meta_reg;
  logic [1:0] pin_reg;
  logic [1:0] lvl;

  always_ff @(posedge linkClk or posedge sys_rst)
    if (sys_rst)
    begin
      meta_reg <= twowire_pkg::LINES_IDLE;
      pin_reg  <= twowire_pkg::LINES_IDLE;
    end
    else
    begin
      meta_reg <= {sclPin, sdaPin};
      pin_reg  <= meta_reg;
    end

  // a new level must persist CYCLES samples before it is passed on
  for (genvar i = 0; i < 2; i++)
  begin : g_line
    logic          level_reg;
    logic [CW-1:0] cnt_reg;
    always_ff @(posedge linkClk or posedge sys_rst)
      if (sys_rst)
      begin
        level_reg <= twowire_pkg::LINES_IDLE[i];
        cnt_reg   <= '0;
      end
      else if (pin_reg[i] == level_reg)
        cnt_reg <= '0;
      else if (cnt_reg == CW'(CYCLES - 1))
      begin
        level_reg <= pin_reg[i];
        cnt_reg   <= '0;
      end
      else
        cnt_reg <= cnt_reg + 1'b1;
    assign lvl[i] = level_reg;
  end

  assign lines.scl = lvl[1];
  assign lines.sda = lvl[0];
endmodule : line_filter

//--- verilog/line_sync.sv
// brings the filtered line levels into the core clock domain
`timescale 1ns/10ps
module line_sync
(
  input  wire logic     clk,
  input  wire logic     sys_rst,
  twowire_lines_if.core lines,
  output logic          sclNow,
  output logic          sdaNow
);
  logic [1:0] meta_reg;
  logic [1:0] hold_reg;

  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      meta_reg <= twowire_pkg::LINES_IDLE;
      hold_reg <= twowire_pkg::LINES_IDLE;
    end
    else
    begin
      meta_reg <= {lines.scl, lines.sda};
      hold_reg <= meta_reg;
    end

  assign sclNow = hold_reg[1];
  assign sdaNow = hold_reg[0];
endmodule : line_sync

//--- bench/twowire_master_model.sv
// behavioural two-wire bus master standing on the far side of the slave
`timescale 1ns/10ps
module twowire_master_model
(
  input  wire logic sclLine,
  input  wire logic sdaLine,
  output logic      sclRel,
  output logic      sdaRel
);
  int stalls;
  initial
  begin
    sclRel = 1'b1;
    sdaRel = 1'b1;
    stalls = 0;
  end
  // waits out clock stretching, bounded so a stuck slave is counted
  task automatic sclUp();
    int n;
    sclRel = 1'b1;
    n = 0;
    while (sclLine !== 1'b1 && n < 4000)
    begin
      #10;
      n++;
    end
    if (n >= 4000)
      stalls++;
    #200;
  endtask : sclUp
  task automatic start();
    sdaRel = 1'b1;
    sclUp();
    sdaRel = 1'b0;
    #200;
    sclRel = 1'b0;
    #100;
  endtask : start
  task automatic stop();
    sdaRel = 1'b0;
    #100;
    sclUp();
    sdaRel = 1'b1;
    #200;
  endtask : stop
  // eight bits msb first then a ninth; line read while clock is high
  task automatic xfer(input logic [7:0] d, input logic ninth,
                      output logic [7:0] q, output logic ack);
    logic [8:0] v;
    v = {d, ninth};
    for (int i = 8; i >= 0; i--)
    begin
      sdaRel = v[i];
      #100;
      sclUp();
      if (i > 0)
        q[i-1] = sdaLine;
      else
        ack = sdaLine;
      sclRel = 1'b0;
      #100;
    end
  endtask : xfer
endmodule : twowire_master_model

//--- bench/twowire_iface_tb_top.sv
// self-checking bench for the two-wire interface
`timescale 1ns/10ps
module twowire_iface_tb_top;
  logic        clk, sys_rst, linkClk, sclRel, sdaRel, a;
  wire logic   sclPin, sdaPin;
  logic        sclOut, sclOe_n, sdaOut, sdaOe_n, sdaSampledIn;
  logic        masterSelectBit, sdaDriveEnable, sdaOutValue, sclOutValue;
  logic        serialPeriphSelectBit, interfaceResetBit, globalIrqEnable;
  logic        ownAddrWrite, dataWrite, dataRead, coreIrq, slaveHalted;
  logic        byteDoneFlag, transmitDirectionFlag;
  logic [7:0]  interruptEnableReg2, ownAddrData, ownAddress;
  logic [7:0]  dataWrData, byteData, d, q;
  logic [15:0] irqVector;
  logic [6:0]  addr;
  int          seed, miscompares, n_checks;
  int          expQ[$];

  // open-drain wires with pull-ups; the master model only pulls low
  assign sclPin = (sclOe_n === 1'b0 ? sclOut : 1'b1) & sclRel;
  assign sdaPin = (sdaOe_n === 1'b0 ? sdaOut : 1'b1) & sdaRel;

  twowire_iface twowire_iface_inst (.clk, .sys_rst, .linkClk, .sclPin,
    .sdaPin, .sclOut, .sclOe_n, .sdaOut, .sdaOe_n, .masterSelectBit,
    .sdaDriveEnable, .sdaOutValue, .sclOutValue, .sdaSampledIn,
    .serialPeriphSelectBit, .interfaceResetBit, .interruptEnableReg2,
    .globalIrqEnable, .ownAddrWrite, .ownAddrData, .ownAddress, .dataWrite,
    .dataRead, .dataWrData, .byteData, .byteDoneFlag,
    .transmitDirectionFlag, .slaveHalted, .coreIrq, .irqVector);
  twowire_master_model twowire_master_model_inst (.sclLine(sclPin),
    .sdaLine(sdaPin), .sclRel(sclRel), .sdaRel(sdaRel));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  initial linkClk = 1'b0;
  // odd start offset keeps the link clock out of phase with clk
  always
  begin
    #7.3;
    forever #15 linkClk = ~linkClk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  // waits for the byte flag, then compares against the model queue
  task automatic gotByte();
    int n;
    n = 0;
    while (byteDoneFlag !== 1'b1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000)
    begin
      miscompares++;
      print_verdict();
    end
    else
      chk(byteData, 16'(expQ.pop_front()));
  endtask : gotByte
  task automatic access(input logic wr, input logic [7:0] v);
    @(negedge clk);
    dataWrite = wr;
    dataRead = !wr;
    dataWrData = v;
    @(negedge clk);
    dataWrite = 1'b0;
    dataRead = 1'b0;
  endtask : access
  task automatic addrByte(input logic rw);
    twowire_master_model_inst.start();
    expQ.push_back({addr, rw});
    twowire_master_model_inst.xfer({addr, rw}, 1'b1, q, a);
    chk(a, 1'b0);
    gotByte();
    chk(transmitDirectionFlag, rw);
  endtask : addrByte

  initial
  begin
    {masterSelectBit, sdaDriveEnable, sdaOutValue, sclOutValue} = 4'h0;
    {serialPeriphSelectBit, interfaceResetBit, globalIrqEnable} = 3'h0;
    {ownAddrWrite, dataWrite, dataRead} = 3'h0;
    {interruptEnableReg2, ownAddrData, dataWrData} = 24'h000000;
    {miscompares, n_checks} = 0;
    seed = 32'h04C8;
    sys_rst = 1'b1;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    chk({byteData, ownAddress}, 16'h0055);
    chk({sclOe_n, sdaOe_n, byteDoneFlag, slaveHalted}, 4'hC);
    chk(irqVector, 16'h003B);
    addr = 7'($random(seed));
    @(negedge clk);
    ownAddrWrite = 1'b1;
    ownAddrData = {1'b0, addr};
    @(negedge clk);
    ownAddrWrite = 1'b0;
    chk(ownAddress, {1'b0, addr});
    interruptEnableReg2 = 8'h01;
    globalIrqEnable = 1'b1;
    // slave receive: address byte then a random data byte
    addrByte(1'b0);
    @(negedge clk);
    chk(coreIrq, 1'b1);
    repeat (10) @(negedge clk);
    chk({sclOe_n, sclPin}, 2'h0);
    access(1'b0, 8'h00);
    @(negedge clk);
    chk({byteDoneFlag, coreIrq}, 2'h0);
    globalIrqEnable = 1'b0;
    d = 8'($random(seed));
    expQ.push_back(d);
    twowire_master_model_inst.xfer(d, 1'b1, q, a);
    gotByte();
    @(negedge clk);
    chk(coreIrq, 1'b0);
    access(1'b0, 8'h00);
    twowire_master_model_inst.stop();
    // slave transmit, master ends the sequence with a nack
    addrByte(1'b1);
    d = 8'($random(seed));
    access(1'b1, d);
    twowire_master_model_inst.xfer(8'hFF, 1'b1, q, a);
    chk(q, d);
    repeat (100) @(negedge clk);
    chk({byteDoneFlag, sclOe_n}, 2'h1);
    twowire_master_model_inst.stop();
    // foreign address is left unanswered
    twowire_master_model_inst.start();
    twowire_master_model_inst.xfer({addr ^ 7'h01, 1'b0}, 1'b1, q, a);
    repeat (100) @(negedge clk);
    chk({a, byteDoneFlag}, 2'h2);
    twowire_master_model_inst.stop();
    // second data access for one flag halts until interface reset
    addrByte(1'b0);
    access(1'b0, 8'h00);
    access(1'b0, 8'h00);
    repeat (3) @(negedge clk);
    chk(slaveHalted, 1'b1);
    interfaceResetBit = 1'b1;
    repeat (4) @(negedge clk);
    chk({slaveHalted, byteDoneFlag, sclOe_n}, 3'h1);
    interfaceResetBit = 1'b0;
    twowire_master_model_inst.stop();
    // software master: pins follow the control bits
    masterSelectBit = 1'b1;
    sdaDriveEnable = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      sclOutValue = i[0];
      sdaOutValue = i[1];
      repeat (2) @(negedge clk);
      chk({sclOe_n, sclOut, sdaOe_n, sdaOut}, {1'b0, i[0], 1'b0, i[1]});
    end
    sdaDriveEnable = 1'b0;
    for (int b = 0; b < 2; b++)
    begin
      sclOutValue = 1'b0;
      twowire_master_model_inst.sdaRel = b[0];
      repeat (40) @(negedge clk);
      chk(sdaOe_n, 1'b1);
      sclOutValue = 1'b1;
      repeat (40) @(negedge clk);
      twowire_master_model_inst.sdaRel = !b[0];
      repeat (40) @(negedge clk);
      chk(sdaSampledIn, b[0]);
    end
    twowire_master_model_inst.sdaRel = 1'b1;
    serialPeriphSelectBit = 1'b1;
    repeat (2) @(negedge clk);
    chk({sclOe_n, sdaOe_n}, 2'h3);
    chk(16'(twowire_master_model_inst.stalls), 16'h0000);
    print_verdict();
  end
endmodule : twowire_iface_tb_top
